/* File: hdl/emprb_cfg.svh */
/*
 Timing and reset constants for the emulator probe signal block.
 Assumes inclusion by bare name from hdl/ and a 125 MHz processor clock.
*/
`ifndef EMPRB_CFG_SVH
`define EMPRB_CFG_SVH
`define EMPRB_CLK_MHZ          125
`define EMPRB_INIT_PULSE_US    550
`define EMPRB_INIT_CYCLES      (`EMPRB_INIT_PULSE_US * `EMPRB_CLK_MHZ)
`define EMPRB_LEAD_CYCLES      4
`define EMPRB_TAIL_CYCLES      7
`define EMPRB_CNT_W            17
`define EMPRB_SMALL_W          3
`define EMPRB_INIT_LAST        1
`endif

/* File: hdl/emprb_pkg.sv */
/*
 Types shared by the emulator probe signal block.
 Assumes no surroundings beyond the compile order.
*/
`include "emprb_cfg.svh"
package emprb_pkg;
    typedef enum logic [2:0] {
        EMPRB_IDLE,
        EMPRB_LEAD,
        EMPRB_RUN,
        EMPRB_FINISH,
        EMPRB_TAIL,
        EMPRB_SELFTEST
    } emprb_state_e;
    typedef logic [`EMPRB_CNT_W-1:0] emprb_cnt_t;
endpackage : emprb_pkg

/* File: hdl/emprb_probe.sv */
/*
 Probe box coordination lines: init pulse, emulation flag, external break and match pulse.
 Assumes synchronous inputs on ref_clk, a core that fetches on fetch_strobe and reports
 instruction and bus cycle boundaries, and user interrupt requests to be gated here.
*/
//
// Contract
// RQ1 - Reset hardware command gives one 550 us low pulse on init_out_n.
// RQ2 - emulating_flag is high exactly while emulating, output only.
// RQ3 - emulating_flag rises four clocks before the first instruction fetch.
// RQ4 - emulating_flag falls seven clocks after the last emulated bus cycle.
// RQ5 - Only a falling edge on external_break_in requests a break.
// RQ6 - On external break, current instruction finishes, then emulation ends.
// RQ7 - external_break_in never starts emulation.
// RQ8 - A breakpoint condition gives one clock low pulse on breakpoint_match_n.
// RQ9 - Only enabled breakpoint registers end emulation; others only pulse.
// RQ10 - Internal clock select holds breakpoint_match_n high.
// RQ11 - Reset clears test parameters, then a pass/fail self check runs.
// RQ12 - Two independent breakpoint registers, either sources the match pulse.
// RQ13 - Outside emulation, user NMI and reset are ignored; hold passes.
// RQ14 - external_break_in passes two flip-flops before edge detection.
`timescale 1ns/1ps
`include "emprb_cfg.svh"
module emprb_probe
    import emprb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        reset_hw_cmd,
    input  wire logic        go_cmd,
    input  wire logic        go_register_command,
    input  wire logic [1:0]  bp_enable_in,
    input  wire logic [1:0]  bp_cond_in,
    input  wire logic        internal_clock_select,
    input  wire logic        external_break_in,
    input  wire logic        instr_done,
    input  wire logic        bus_cycle_done,
    input  wire logic        selftest_ok_in,
    input  wire logic        user_nmi_in,
    input  wire logic        user_reset_in,
    input  wire logic        user_hold_in,
    output logic             init_out_n,
    output logic             emulating_flag,
    output logic             breakpoint_match_n,
    output logic             fetch_strobe,
    output logic             core_run,
    output logic             selftest_pass,
    output logic             selftest_done,
    output logic             core_nmi,
    output logic             core_reset,
    output logic             core_hold,
    output logic [1:0]       bp_armed
);
    emprb_state_e state_reg;
    emprb_state_e state_next;
    emprb_cnt_t   init_cnt_reg;
    logic [`EMPRB_SMALL_W-1:0] seq_cnt_reg;
    logic [`EMPRB_SMALL_W-1:0] seq_cnt_next;
    logic         brk_sync1_reg;
    logic         brk_sync2_reg;
    logic         brk_prev_reg;
    logic         brk_pend_reg;
    logic [1:0]   bp_en_reg;

    wire brk_fall    = brk_prev_reg & ~brk_sync2_reg;          // see RQ5
    wire bp_any      = |bp_cond_in;                           // see RQ12
    wire bp_hit_brk  = |(bp_cond_in & bp_en_reg);             // see RQ9
    wire in_run      = (state_reg == EMPRB_RUN);
    wire stop_req    = in_run & (brk_pend_reg | brk_fall | bp_hit_brk);
    wire start_req   = (go_cmd | go_register_command) & (state_reg == EMPRB_IDLE); // see RQ7
    wire lead_done   = (seq_cnt_reg == `EMPRB_SMALL_W'(`EMPRB_LEAD_CYCLES - 1));
    wire tail_done   = (seq_cnt_reg == `EMPRB_SMALL_W'(`EMPRB_TAIL_CYCLES - 1));
    wire emulating_flag_now    = (state_next == EMPRB_LEAD) | (state_next == EMPRB_RUN) |
                       (state_next == EMPRB_FINISH) | (state_next == EMPRB_TAIL);
    wire init_busy   = (init_cnt_reg != '0);

    always_comb begin
        state_next   = state_reg;
        seq_cnt_next = '0;
        case (state_reg)
            EMPRB_SELFTEST: state_next = EMPRB_IDLE;          // see RQ11
            EMPRB_IDLE: begin
                if (start_req) begin
                    state_next = EMPRB_LEAD;                  // see RQ3
                end
            end
            EMPRB_LEAD: begin
                seq_cnt_next = seq_cnt_reg + 1'b1;
                if (lead_done) begin
                    state_next   = EMPRB_RUN;
                    seq_cnt_next = '0;
                end
            end
            EMPRB_RUN: begin
                if (stop_req) begin
                    state_next = EMPRB_FINISH;                // see RQ6
                end
            end
            EMPRB_FINISH: begin
                if (instr_done & bus_cycle_done) begin
                    state_next = EMPRB_TAIL;                  // see RQ4
                end
            end
            EMPRB_TAIL: begin
                seq_cnt_next = seq_cnt_reg + 1'b1;
                if (tail_done) begin
                    state_next   = EMPRB_IDLE;
                    seq_cnt_next = '0;
                end
            end
            default: state_next = EMPRB_IDLE;
        endcase
    end

    // The state register starts in self-test so that every reset runs the check.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= EMPRB_SELFTEST;                      // see RQ11
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            seq_cnt_reg <= '0;
        end else begin
            seq_cnt_reg <= seq_cnt_next;
        end
    end

    // The break line passes two stages before its edge history is kept.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            brk_sync1_reg <= 1'b1;
        end else begin
            brk_sync1_reg <= external_break_in;               // see RQ14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            brk_sync2_reg <= 1'b1;
        end else begin
            brk_sync2_reg <= brk_sync1_reg;                   // see RQ14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            brk_prev_reg <= 1'b1;
        end else begin
            brk_prev_reg <= brk_sync2_reg;                    // see RQ5
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || state_reg != EMPRB_RUN) begin
            brk_pend_reg <= 1'b0;
        end else if (brk_fall) begin
            brk_pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bp_en_reg <= '0;                                  // see RQ11
        end else if (start_req) begin
            bp_en_reg <= bp_enable_in;                        // see RQ9
        end
    end

    logic       init_load;
    logic       init_hold;
    emprb_cnt_t init_cnt_next;
    logic       in_selftest;
    logic       init_out_n_next;
    logic       emulating_flag_next;
    logic       breakpoint_match_n_next;
    logic       fetch_strobe_next;
    logic       core_run_next;
    logic       selftest_pass_next;
    logic       selftest_done_next;
    logic       core_nmi_next;
    logic       core_reset_next;
    logic       core_hold_next;
    logic [1:0] bp_armed_next;

    // Next values of the output registers, so that each output leaves a flip-flop.
    assign init_load               = reset_hw_cmd & ~init_busy;         // see RQ1
    assign init_hold               = (init_cnt_reg > emprb_cnt_t'(`EMPRB_INIT_LAST));
    assign init_cnt_next           = init_load ? emprb_cnt_t'(`EMPRB_INIT_CYCLES) :
                                     init_busy ? init_cnt_reg - 1'b1 : init_cnt_reg;
    assign in_selftest             = (state_reg == EMPRB_SELFTEST);
    assign init_out_n_next         = ~(init_load | init_hold);          // see RQ1
    assign emulating_flag_next     = emulating_flag_now;                          // see RQ2
    assign breakpoint_match_n_next = ~(bp_any & ~internal_clock_select); // see RQ8 see RQ10
    assign fetch_strobe_next       = (state_reg == EMPRB_LEAD) & lead_done; // see RQ3
    assign core_run_next           = (state_next == EMPRB_RUN) | (state_next == EMPRB_FINISH);
    assign selftest_pass_next      = in_selftest ? selftest_ok_in : selftest_pass; // see RQ11
    assign selftest_done_next      = in_selftest | selftest_done;       // see RQ11
    assign core_nmi_next           = user_nmi_in & in_run;              // see RQ13
    assign core_reset_next         = user_reset_in & in_run;            // see RQ13
    assign core_hold_next          = user_hold_in;                      // see RQ13
    assign bp_armed_next           = bp_en_reg;                         // see RQ9

    // A command that arrives while a pulse is running is ignored.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            init_cnt_reg <= '0;
        end else begin
            init_cnt_reg <= init_cnt_next;
        end
    end

    // One short register per output keeps the reset values easy to audit.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            init_out_n <= 1'b1;
        end else begin
            init_out_n <= init_out_n_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            emulating_flag <= 1'b0;
        end else begin
            emulating_flag <= emulating_flag_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            breakpoint_match_n <= 1'b1;
        end else begin
            breakpoint_match_n <= breakpoint_match_n_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fetch_strobe <= 1'b0;
        end else begin
            fetch_strobe <= fetch_strobe_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_run <= 1'b0;
        end else begin
            core_run <= core_run_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            selftest_pass <= 1'b0;
        end else begin
            selftest_pass <= selftest_pass_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            selftest_done <= 1'b0;
        end else begin
            selftest_done <= selftest_done_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_nmi <= 1'b0;
        end else begin
            core_nmi <= core_nmi_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_reset <= 1'b0;
        end else begin
            core_reset <= core_reset_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            core_hold <= 1'b0;
        end else begin
            core_hold <= core_hold_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bp_armed <= '0;
        end else begin
            bp_armed <= bp_armed_next;
        end
    end
endmodule : emprb_probe

/* File: test/emprb_probe_monitor.sv */
/* Checker for the probe signal block, watching only its ports.
   Assumes the bind at the foot and a single synchronous reset domain. */
`timescale 1ns/1ps
module emprb_monitor (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       reset_hw_cmd,
    input wire logic       go_cmd,
    input wire logic       go_register_command,
    input wire logic [1:0] bp_cond_in,
    input wire logic       internal_clock_select,
    input wire logic       instr_done,
    input wire logic       bus_cycle_done,
    input wire logic       init_out_n,
    input wire logic       emulating_flag,
    input wire logic       breakpoint_match_n,
    input wire logic       fetch_strobe,
    input wire logic       core_nmi,
    input wire logic       core_reset
);
    logic [16:0] lo_cnt;
    always_ff @(posedge ref_clk) lo_cnt <= (reset || init_out_n) ? 17'h0 : lo_cnt + 17'h1;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_init_width: assert property ($rose(init_out_n) |-> lo_cnt == 17'h1_0C8E)
        else $error("init pulse width wrong");
    a_init_cause: assert property ($fell(init_out_n) |-> $past(reset_hw_cmd))
        else $error("init pulse without command");
    a_match_pulse: assert property (|bp_cond_in && !internal_clock_select |=> !breakpoint_match_n)
        else $error("match pulse missing");
    a_match_cause: assert property (!breakpoint_match_n |-> $past(|bp_cond_in))
        else $error("match pulse without condition");
    a_match_sel: assert property (internal_clock_select |=> breakpoint_match_n)
        else $error("match pulse under internal clock");
    a_flag_lead: assert property ($rose(emulating_flag) |-> ##4 fetch_strobe)
        else $error("flag lead wrong");
    a_flag_cause: assert property ($rose(emulating_flag) |-> $past(go_cmd || go_register_command))
        else $error("run started without go");
    a_flag_tail: assert property ($fell(emulating_flag) |-> $past(instr_done && bus_cycle_done, 8))
        else $error("flag tail wrong");
    a_user_gate: assert property (!emulating_flag ##1 !emulating_flag |-> !core_nmi && !core_reset)
        else $error("user request passed outside run");
    cover property ($fell(emulating_flag));
    cover property ($rose(init_out_n));
    cover property (!breakpoint_match_n);
endmodule : emprb_monitor
bind emprb_probe emprb_monitor i_mon (.*);

/* File: test/emprb_user_model.sv */
/* User hardware model: break line and instruction completion pulses.
   Assumes ref_clk and brk_req from the bench, core_run from the probe. */
`timescale 1ns/1ps
module emprb_user_model (
    input  wire logic ref_clk,
    input  wire logic brk_req,
    input  wire logic core_run,
    output logic      external_break_in = 1'b1,
    output logic      instr_done = 1'b0
);
    logic [1:0] ph_reg = 2'h0;
    always @(posedge ref_clk) begin
        ph_reg            <= core_run ? ph_reg + 2'h1 : 2'h0;
        instr_done        <= core_run && ph_reg == 2'h3;
        external_break_in <= !brk_req;
    end
endmodule : emprb_user_model

/* File: test/test_emulator_probe_signals.sv */
/* Self-checking bench for the probe signal block.
   Assumes the user model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module test_emulator_probe_signals;
    logic       ref_clk, reset, reset_hw_cmd, go_cmd, go_register_command, selftest_pass;
    logic       internal_clock_select, user_nmi_in, brk_req, external_break_in, instr_done;
    logic       init_out_n, emulating_flag, breakpoint_match_n, fetch_strobe, core_run, core_nmi;
    logic       core_reset, core_hold, selftest_done, selftest_ok;
    logic [1:0] bp_enable_in, bp_cond_in, bp_armed;
    int         num_errors, n_compared, cyc, n;
    emprb_probe i_dut (.*, .bus_cycle_done(instr_done), .selftest_ok_in(selftest_ok),
        .user_reset_in(user_nmi_in), .user_hold_in(user_nmi_in), .selftest_done(selftest_done),
        .core_reset(core_reset), .core_hold(core_hold), .bp_armed(bp_armed));
    emprb_user_model i_user (.ref_clk, .brk_req, .core_run, .external_break_in, .instr_done);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic final_report;
        if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic pulse_bp(input logic [1:0] c);
        @(posedge ref_clk) bp_cond_in <= c;
        @(posedge ref_clk) bp_cond_in <= 2'h0;
        #1;
    endtask : pulse_bp
    task automatic t_idle;
        @(posedge ref_clk) user_nmi_in <= 1'b1;
        brk_req               <= 1'b1;
        internal_clock_select <= 1'b1;
        pulse_bp(2'h3);
        chk("match_sel", 1, breakpoint_match_n);
        @(posedge ref_clk) internal_clock_select <= 1'b0;
        tick(8);
        chk("no_start", 0, emulating_flag);
        chk("nmi_gate", 0, core_nmi);
        chk("rst_gate", 0, core_reset);
        chk("hold_idle", 1, core_hold);
    endtask : t_idle
    task automatic t_run(input logic rf, input logic by_bp);
        @(posedge ref_clk) bp_enable_in <= 2'h2;
        go_cmd              <= !rf;
        go_register_command <= rf;
        @(posedge ref_clk) go_cmd <= 1'b0;
        go_register_command <= 1'b0;
        #1 n = 0;
        for (int k = 0; k < 12 && fetch_strobe !== 1'b1; k++) begin
            n += (emulating_flag === 1'b1);
            tick(1);
        end
        chk("lead", 4, n);
        chk("armed", 2, bp_armed);
        pulse_bp(2'h1);
        chk("match", 0, breakpoint_match_n);
        tick(1);
        chk("match_end", 1, breakpoint_match_n);
        tick(10);
        chk("no_break", 1, emulating_flag);
        chk("nmi_run", 1, core_nmi);
        chk("rst_run", 1, core_reset);
        if (by_bp) pulse_bp(2'h2);
        else begin
            @(posedge ref_clk) brk_req <= 1'b0;
            tick(3);
            @(posedge ref_clk) brk_req <= 1'b1;
        end
        for (int k = 0; k < 40 && emulating_flag === 1'b1; k++) tick(1);
        chk("stopped", 0, emulating_flag);
    endtask : t_run
    task automatic t_reset(input logic ok);
        @(posedge ref_clk) reset <= 1'b1;
        selftest_ok <= ok;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        tick(3);
        chk("rst_pass", ok, selftest_pass);
        chk("rst_done", 1, selftest_done);
        chk("rst_armed", 0, bp_armed);
        chk("rst_flag", 0, emulating_flag);
    endtask : t_reset
    task automatic t_init;
        @(posedge ref_clk) reset_hw_cmd <= 1'b1;
        @(posedge ref_clk) reset_hw_cmd <= 1'b0;
        #1 n = 0;
        while (init_out_n === 1'b0 && n < 70000) begin
            n++;
            tick(1);
        end
        chk("init_len", 68750, n);
    endtask : t_init
    initial begin
        {reset, reset_hw_cmd, go_cmd, go_register_command} = 4'h8;
        {internal_clock_select, user_nmi_in, brk_req, bp_enable_in, bp_cond_in} = 7'h0;
        selftest_ok = 1'b1;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        tick(3);
        chk("clr_flag", 0, emulating_flag);
        chk("selftest", 1, selftest_pass);
        chk("st_done", 1, selftest_done);
        t_idle();
        t_run(1'b1, 1'b1);
        t_run(1'b0, 1'b0);
        t_reset(1'b0);
        t_init();
        final_report();
    end
endmodule : test_emulator_probe_signals
